/* core/sis_top.v */
// Serializer interrupt status, blanking video control and power-down reset with a serial slave.
//
// Notes on behaviour
// - Status bit 5 at 0xc7 reports a downstream receiver interrupt request.
// - Status bit 0 is set whenever any enabled interrupt source indicates.
// - By default pixel words are still sent while data-valid is low.
// - Last pixel 666666 sent into blanking makes the far deserializer mute.
// - Writing one to bit 1 of 0x04 stops video during blanking.
// - Power-up completes just over 1 ms after release; register access allowed after.
// - Control bit 5 at 0xc6 gates downstream interrupts into status.
// - Control bit 0 at 0xc6 gates the interrupt output toward the controller.
`timescale 1ns/1ps
`include "sis_map.vh"
module sis_top #(
  parameter STARTUP_CYCLES = `SIS_STARTUP_CYCLES,
  parameter [6:0] DEV_ADDR = `SIS_DEV_ADDR
) (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire remote_receiver_int_req,
  input wire [23:0] pixel_in,
  input wire pixel_data_valid,
  output wire [23:0] tx_pixel,
  output wire tx_data_valid,
  output wire tx_send,
  output wire mute_pattern_sent,
  output wire int_out,
  output wire ready
);
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ACK_A = 4'h2;
  localparam [3:0] ST_WREG = 4'h3;
  localparam [3:0] ST_ACK_R = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_ACK_D = 4'h6;
  localparam [3:0] ST_RDATA = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;
  localparam [31:0] STARTUP_W = STARTUP_CYCLES;
  localparam [16:0] STARTUP_LAST = STARTUP_W[16:0] - 17'h00001;

  reg rst_s1_r, rst_s2_r;
  wire rst_sync_n;
  wire [1:0] bus_f;
  wire scl_f, sda_f;
  reg scl_q_r, sda_q_r;
  wire start_c, stop_c, scl_rise, scl_fall;
  reg [16:0] su_cnt_r;
  reg ready_r;
  reg [3:0] state_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] tx_r;
  reg [7:0] ptr_r;
  reg rw_r, nack_r, oe_r;
  reg [7:0] video_ctrl_r;
  reg [7:0] int_ctrl_r;
  wire [7:0] int_status;
  wire [7:0] rd_addr;
  wire [7:0] rd_here;
  wire blank_suppress;
  reg [23:0] tx_pixel_r;
  reg [23:0] last_pix_r;
  reg tx_valid_r, tx_send_r, de_q_r, mute_r, int_r;

  // Power-down pin acts as reset; assertion is immediate, release passes two flops.
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      {rst_s2_r, rst_s1_r} <= 2'b00;
    else
      {rst_s2_r, rst_s1_r} <= {rst_s1_r, 1'b1};
  end
  assign rst_sync_n = rst_s2_r;

  // Bus pins come from outside the clock domain and are filtered.
  sis_sync #(.W(2), .INIT(2'b11)) u_sync (
    .clk(clk),
    .rst_n(rst_sync_n),
    .din({scl_in, sda_in}),
    .dout(bus_f)
  );
  assign scl_f = bus_f[1];
  assign sda_f = bus_f[0];

  // Edge and condition detection on the filtered bus lines.
  always @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      {scl_q_r, sda_q_r} <= 2'b11;
    else
      {scl_q_r, sda_q_r} <= {scl_f, sda_f};
  end
  assign start_c = scl_f & scl_q_r & sda_q_r & ~sda_f;
  assign stop_c = scl_f & scl_q_r & ~sda_q_r & sda_f;
  assign scl_rise = scl_f & ~scl_q_r;
  assign scl_fall = ~scl_f & scl_q_r;

  // Startup timer; the register port stays deaf until it expires.
  always @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      su_cnt_r <= 17'h00000;
      ready_r <= 1'b0;
    end
    else if (!ready_r)
    begin
      if (su_cnt_r == STARTUP_LAST)
        ready_r <= 1'b1;
      else
        su_cnt_r <= su_cnt_r + 17'h00001;
    end
  end

  // Status is live: each bit shows the current, gated source level.
  assign int_status[7:6] = 2'b00;
  assign int_status[`SIS_BIT_RX_INT] = remote_receiver_int_req
                                     & int_ctrl_r[`SIS_BIT_RX_INT];
  assign int_status[4:1] = 4'h0;
  assign int_status[`SIS_BIT_GLOBAL_INT] = int_status[`SIS_BIT_RX_INT];
  assign blank_suppress = video_ctrl_r[`SIS_BIT_BLANK_SUPPRESS];

  // Read multiplexer; looks one byte ahead while a read byte is acknowledged, unmapped reads zero.
  assign rd_addr = (state_r == ST_RACK) ? ptr_r + 8'h01 : ptr_r;
  assign rd_here = (rd_addr == `SIS_ADDR_VIDEO_CTRL) ? video_ctrl_r :
                   (rd_addr == `SIS_ADDR_INT_CTRL) ? int_ctrl_r :
                   (rd_addr == `SIS_ADDR_INT_STATUS) ? int_status : 8'h00;

  // Serial control slave: address, register pointer, then data bytes with auto-increment.
  always @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      {rw_r, nack_r, oe_r} <= 3'b000;
      video_ctrl_r <= `SIS_RST_VIDEO_CTRL;
      int_ctrl_r <= `SIS_RST_INT_CTRL;
    end
    else if (stop_c)
    begin
      state_r <= ST_IDLE;
      oe_r <= 1'b0;
    end
    else if (start_c)
    begin
      state_r <= ready_r ? ST_ADDR : ST_IDLE;
      bit_cnt_r <= 4'h0;
      oe_r <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (state_r == ST_ADDR || state_r == ST_WREG || state_r == ST_WDATA)
      begin
        shift_r <= {shift_r[6:0], sda_f};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (state_r == ST_RACK)
        nack_r <= sda_f;
    end
    else if (scl_fall)
    begin
      case (state_r)
        ST_ADDR:
          if (bit_cnt_r == 4'h8)
          begin
            if (shift_r[7:1] == DEV_ADDR)
            begin
              rw_r <= shift_r[0];
              state_r <= ST_ACK_A;
              oe_r <= 1'b1;
            end
            else
              state_r <= ST_IDLE;
          end
        ST_ACK_A:
        begin
          bit_cnt_r <= 4'h0;
          if (rw_r)
          begin
            tx_r <= rd_here;
            oe_r <= ~rd_here[7];
            state_r <= ST_RDATA;
          end
          else
          begin
            oe_r <= 1'b0;
            state_r <= ST_WREG;
          end
        end
        ST_WREG:
          if (bit_cnt_r == 4'h8)
          begin
            ptr_r <= shift_r;
            state_r <= ST_ACK_R;
            oe_r <= 1'b1;
          end
        ST_WDATA:
          if (bit_cnt_r == 4'h8)
          begin
            // Status register is read-only; writes to it are acknowledged and dropped.
            if (ptr_r == `SIS_ADDR_VIDEO_CTRL)
              video_ctrl_r <= shift_r;
            if (ptr_r == `SIS_ADDR_INT_CTRL)
              int_ctrl_r <= shift_r & 8'h21;
            ptr_r <= ptr_r + 8'h01;
            state_r <= ST_ACK_D;
            oe_r <= 1'b1;
          end
        ST_ACK_R, ST_ACK_D:
        begin
          oe_r <= 1'b0;
          bit_cnt_r <= 4'h0;
          state_r <= ST_WDATA;
        end
        ST_RDATA:
          if (bit_cnt_r == 4'h7)
          begin
            oe_r <= 1'b0;
            state_r <= ST_RACK;
          end
          else
          begin
            tx_r <= {tx_r[6:0], 1'b0};
            oe_r <= ~tx_r[6];
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
        ST_RACK:
          if (nack_r)
            state_r <= ST_IDLE;
          else
          begin
            ptr_r <= ptr_r + 8'h01;
            tx_r <= rd_here;
            oe_r <= ~rd_here[7];
            bit_cnt_r <= 4'h0;
            state_r <= ST_RDATA;
          end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Video forwarding; blanking words go out unless suppression is set.
  always @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tx_pixel_r <= 24'h000000;
      last_pix_r <= 24'h000000;
      {tx_valid_r, tx_send_r, de_q_r, mute_r, int_r} <= 5'h00;
    end
    else
    begin
      de_q_r <= pixel_data_valid;
      tx_valid_r <= pixel_data_valid;
      if (pixel_data_valid)
        last_pix_r <= pixel_in;
      if (!pixel_data_valid && blank_suppress)
      begin
        tx_pixel_r <= 24'h000000;
        tx_send_r <= 1'b0;
      end
      else
      begin
        tx_pixel_r <= pixel_in;
        tx_send_r <= 1'b1;
      end
      // Flags the first blanking word after a frame ending in the mute pattern.
      mute_r <= de_q_r & ~pixel_data_valid & ~blank_suppress
              & (last_pix_r == `SIS_MUTE_PATTERN);
      // Interrupt output toward the controller, gated by the global enable.
      int_r <= int_status[`SIS_BIT_GLOBAL_INT] & int_ctrl_r[`SIS_BIT_GLOBAL_INT];
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_r;
  assign tx_pixel = tx_pixel_r;
  assign tx_data_valid = tx_valid_r;
  assign tx_send = tx_send_r;
  assign mute_pattern_sent = mute_r;
  assign int_out = int_r;
  assign ready = ready_r;
endmodule

/* core/sis_map.vh */
// Register offsets, field positions, reset values and timing for the serializer status block.
`ifndef SIS_MAP_VH
`define SIS_MAP_VH
`define SIS_ADDR_VIDEO_CTRL 8'h04
`define SIS_ADDR_INT_CTRL 8'hc6
`define SIS_ADDR_INT_STATUS 8'hc7
`define SIS_BIT_BLANK_SUPPRESS 1
`define SIS_BIT_RX_INT 5
`define SIS_BIT_GLOBAL_INT 0
`define SIS_RST_VIDEO_CTRL 8'h00
`define SIS_RST_INT_CTRL 8'h00
`define SIS_MUTE_PATTERN 24'h666666
`define SIS_DEV_ADDR 7'h0c
`define SIS_CLK_PERIOD_PS 8000
`define SIS_T_STARTUP_MS 1
`define SIS_STARTUP_CYCLES ((`SIS_T_STARTUP_MS * 1000000000) / `SIS_CLK_PERIOD_PS)
`endif

/* core/sis_sync.v */
// Three-stage pin synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
module sis_sync #(
  parameter W = 2,
  parameter [W-1:0] INIT = {W{1'b1}}
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] out_r;
  genvar i;

  assign dout = out_r;

  // Each bit is sampled three times; the filtered copy moves only when stages two and three agree.
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_r[i] <= INIT[i];
          s2_r[i] <= INIT[i];
          s3_r[i] <= INIT[i];
          out_r[i] <= INIT[i];
        end
        else
        begin
          s1_r[i] <= din[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i])
            out_r[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule

/* verif/sis_props.sv */
// Port-level checker for the serializer status, blanking and power-down block.
`timescale 1ns/1ps
module sis_props #(
  parameter STARTUP_CYCLES = 16
) (
  input wire clk,
  input wire rst_n,
  input wire sda_oe,
  input wire remote_receiver_int_req,
  input wire [23:0] pixel_in,
  input wire pixel_data_valid,
  input wire [23:0] tx_pixel,
  input wire tx_data_valid,
  input wire tx_send,
  input wire mute_pattern_sent,
  input wire int_out,
  input wire ready
);
  reg [31:0] up_r;
  wire act = up_r >= 3;
  // Counts edges since release so the two-flop reset copy is allowed for.
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      up_r <= 32'h0;
    else if (up_r < STARTUP_CYCLES + 8)
      up_r <= up_r + 32'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_valid_follows: assert property (act |-> tx_data_valid == $past(pixel_data_valid))
    else $error("data valid not delayed by one");
  a_pix_sent: assert property (act && $past(pixel_data_valid) |->
    tx_send && tx_pixel == $past(pixel_in)) else $error("active pixel lost");
  a_idle_blank: assert property (!tx_send |-> tx_pixel == 24'h0 && !tx_data_valid)
    else $error("idle link word not zero");
  a_mute_cause: assert property (mute_pattern_sent |-> tx_send && !tx_data_valid &&
    $past(tx_data_valid) && $past(tx_pixel) == 24'h666666) else $error("stray mute");
  a_mute_once: assert property (mute_pattern_sent |=> !mute_pattern_sent)
    else $error("mute pulse too long");
  a_int_cause: assert property (act && !$past(remote_receiver_int_req) |-> !int_out)
    else $error("interrupt without request");
  a_quiet_reset: assert property (!act |-> !int_out && !tx_send && !sda_oe && !ready)
    else $error("output active in reset");
  a_no_bus_early: assert property (!ready |-> !sda_oe)
    else $error("bus answered before ready");
  a_ready_late: assert property ($rose(ready) |-> up_r >= STARTUP_CYCLES)
    else $error("ready too early");
  a_ready_due: assert property (up_r >= STARTUP_CYCLES + 6 |-> ready)
    else $error("ready too late");
  cover property (mute_pattern_sent);
  cover property (int_out);
  cover property (act && !pixel_data_valid ##1 !tx_send);
endmodule
bind sis_top sis_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (
  .clk(clk), .rst_n(rst_n), .sda_oe(sda_oe), .remote_receiver_int_req(remote_receiver_int_req),
  .pixel_in(pixel_in), .pixel_data_valid(pixel_data_valid), .tx_pixel(tx_pixel),
  .tx_data_valid(tx_data_valid), .tx_send(tx_send), .mute_pattern_sent(mute_pattern_sent),
  .int_out(int_out), .ready(ready));

/* verif/sis_link_model.sv */
// Far-end deserializer model that watches link words for the mute pattern.
`timescale 1ns/1ps
module sis_link_model (
  input wire clk,
  input wire rst_n,
  input wire [23:0] tx_pixel,
  input wire tx_data_valid,
  input wire tx_send,
  output reg far_end_mute_mode
);
  reg [23:0] last_r;
  // A valid word ends mute; a blank word after a mute-pattern pixel starts it.
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      last_r <= 24'h0;
      far_end_mute_mode <= 1'b0;
    end
    else if (tx_send && tx_data_valid)
    begin
      last_r <= tx_pixel;
      far_end_mute_mode <= 1'b0;
    end
    else if (tx_send && last_r == 24'h666666)
      far_end_mute_mode <= 1'b1;
endmodule

/* verif/tb_serializer_int_status_and_reset.sv */
// Self-checking bench for the serializer status, blanking and power-down block.
`timescale 1ns/1ps
module tb_serializer_int_status_and_reset;
  reg clk = 0;
  reg rst_n = 0;
  reg sc = 1;
  reg sd = 1;
  reg req = 0;
  reg dv = 0;
  reg [23:0] pix = 24'h0;
  reg [8:0] q;
  reg [7:0] d;
  wire sda_out;
  wire sda_oe;
  wire [23:0] tx_pixel;
  wire tx_data_valid;
  wire tx_send;
  wire mute;
  wire int_out;
  wire ready;
  wire far_mute;
  // Open-drain line: whichever side pulls low wins, otherwise the pull-up holds it high.
  wire sda = sd & ~(sda_oe & ~sda_out);
  integer bad_count = 0;
  integer checked = 0;
  integer i;
  integer mute_seen = 0;
  // The clock toggles every 4 ns, half of its 8 ns period.
  always #4 clk = ~clk;
  // Counts the one-cycle mute-pattern pulses that the block reports.
  always @(posedge clk)
    if (mute === 1'b1)
      mute_seen <= mute_seen + 1;
  sis_top #(.STARTUP_CYCLES(16)) u_dut (.clk(clk), .rst_n(rst_n), .scl_in(sc), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .remote_receiver_int_req(req), .pixel_in(pix),
    .pixel_data_valid(dv), .tx_pixel(tx_pixel), .tx_data_valid(tx_data_valid),
    .tx_send(tx_send), .mute_pattern_sent(mute), .int_out(int_out), .ready(ready));
  sis_link_model u_far (.clk(clk), .rst_n(rst_n), .tx_pixel(tx_pixel),
    .tx_data_valid(tx_data_valid), .tx_send(tx_send), .far_end_mute_mode(far_mute));
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("BAD at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  // Nine bus bits, MSB first; line level is captured while the clock is high.
  task xfer(input [8:0] v);
    for (i = 8; i >= 0; i = i - 1)
    begin
      sd <= v[i];
      tick(8);
      sc <= 1;
      tick(8);
      q[i] = sda;
      sc <= 0;
      tick(8);
    end
  endtask
  task start;
    sd <= 1;
    tick(8);
    sc <= 1;
    tick(8);
    sd <= 0;
    tick(8);
    sc <= 0;
    tick(8);
  endtask
  task stop;
    sd <= 0;
    tick(8);
    sc <= 1;
    tick(8);
    sd <= 1;
    tick(8);
  endtask
  task wr(input [7:0] a, input [7:0] v);
    start;
    xfer({7'h0c, 2'b01});
    xfer({a, 1'b1});
    xfer({v, 1'b1});
    chk(q[0], 0);
    stop;
  endtask
  task rd(input [7:0] a);
    start;
    xfer({7'h0c, 2'b01});
    xfer({a, 1'b1});
    start;
    xfer({7'h0c, 2'b11});
    chk(q[0], 0);
    xfer(9'h1ff);
    d = q[8:1];
    stop;
  endtask
  task wait_ready;
    for (i = 0; i < 100 && ready !== 1'b1; i = i + 1)
      tick(1);
    chk(ready, 1);
    if (ready !== 1'b1)
      complete_run;
  endtask
  task t_regs;
    rd(8'hc7);
    chk(d, 0);
    rd(8'hc6);
    chk(d, 0);
    rd(8'h04);
    chk(d, 0);
    rd(8'h10);
    chk(d, 0);
    // A foreign device address must go unanswered.
    start;
    xfer({7'h0d, 2'b01});
    chk(q[0], 1);
    stop;
    $display("t_regs done");
  endtask
  task t_irq;
    req <= 1;
    wr(8'hc6, 8'h01);
    rd(8'hc7);
    chk(d, 0);
    wr(8'hc6, 8'h20);
    rd(8'hc7);
    chk(d, 8'h21);
    chk(int_out, 0);
    wr(8'hc7, 8'h00);
    wr(8'hc6, 8'hff);
    rd(8'hc7);
    chk(d, 8'h21);
    chk(int_out, 1);
    req <= 0;
    tick(3);
    chk(int_out, 0);
    $display("t_irq done");
  endtask
  // Sends a two-word line ending in the given pixel, then blanking.
  task frame(input [23:0] last);
    dv <= 1;
    pix <= last;
    tick(2);
    dv <= 0;
    tick(4);
  endtask
  task t_video;
    frame(24'h666666);
    chk(tx_send, 1);
    chk(tx_pixel, 24'h666666);
    chk(far_mute, 1);
    chk(tx_data_valid, 0);
    chk(mute_seen, 1);
    wr(8'h04, 8'h02);
    frame(24'h666666);
    chk(tx_send, 0);
    chk(far_mute, 0);
    chk(mute_seen, 1);
    wr(8'h04, 8'h00);
    frame(24'h666665);
    chk(far_mute, 0);
    chk(mute_seen, 1);
    $display("t_video done");
  endtask
  // Power-down in mid-run; the hold is far shorter than a real hard reset.
  task t_pd;
    req <= 1;
    rst_n <= 0;
    tick(20);
    chk(ready, 0);
    rst_n <= 1;
    wait_ready;
    rd(8'hc7);
    chk(d, 0);
    req <= 0;
    $display("t_pd done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Inputs stay quiet through reset, then power-down is raised.
  initial
  begin
    tick(20);
    rst_n <= 1;
    wait_ready;
    t_regs;
    t_irq;
    t_video;
    t_pd;
    complete_run;
  end
endmodule
